// ==== rtl/rsq_system_sequencer.sv ====
// Reset source sequencer, stabilisation timing and interrupt control top
//
// Behaviour
// - Illegal instruction sets illegal-opcode cause flag and starts internal reset.
// - Stop instruction with stop disabled counts as illegal opcode.
// - Every internal reset source drives the reset pin low.
// - Unmapped address resets only on opcode fetch, never on data fetch.
// - Low voltage sets its flag; pin held low through 4096 fast cycles.
// - After that count, core released a further sixty-four fast cycles later.
// - Twelve counting stages plus a 13th that resets chain and clocks watchdog.
// - Counter advances on the falling edge of the fast clock.
// - Bus clocks stay off during power-on and stop recovery timing.
// - Stop instruction clears the counter.
// - Stop exit samples short recovery bit: 32 cycles if set, else 4096.
// - External reset pin leaves counter alone; counter free-runs after resets.
// - Power-on initialises the sequencer, then oscillator drives the bus clocks.
// - Requests latched and arbitrated at processing start; winner picks the vector.
// - A latched interrupt holds until serviced or global mask cleared.
// - Interrupts never abort an instruction; checked only at its end.
// - Taken only with mask clear and source enabled, else next instruction runs.
// - Highest priority pending request served first, others after its return.
// - Software interrupt is taken whatever the global mask.
// - Fixed priority and vectors from reset down to periodic wakeup.
// - Each maskable source sets its own pending flag.
// - Internal resets drive pin 32 fast cycles, core reset 32 more.
// - Resets share highest priority and bypass interrupt arbitration.
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module rsq_system_sequencer #(
	parameter logic [12:0] LONG_FAST_CYC = rsq_pkg::LONG_RECOVERY
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic power_on_reset_signal,
	input wire logic low_voltage_detector,
	input wire logic illegal_opcode_in,
	input wire logic stop_exec,
	input wire logic unmapped_access,
	input wire logic opcode_fetch,
	input wire logic wdog_timeout,
	input wire logic break_req,
	input wire logic rst_pin_in,
	input wire logic cpu_i_mask,
	input wire logic insn_done,
	input wire logic swi_exec,
	input wire logic int_ack,
	input wire logic [18:0] src_req,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic rst_pin_out,
	output logic rst_pin_oe_n,
	output logic core_reset,
	output logic bus_clk_en,
	output logic osc_enable,
	output logic stop_mode,
	output logic wdog_clk,
	output logic int_req,
	output logic [15:0] int_vector
);

	rsq_pkg::rsq_state_e state_ff;
	rsq_pkg::rsq_state_e nxt_state;
	logic fast_ff;
	logic fast_fall;
	logic [1:0] bus_div_ff;
	logic [12:0] cnt;
	logic cnt_clear;
	logic rec_short_ff;
	logic [7:0] cause_ff;
	logic [1:0] cfg_ff;
	logic [18:0] en_ff;
	logic [18:0] pend;
	logic irq_wake;
	logic src_illegal_opcode_flag;
	logic src_illegal_address_flag;
	logic src_lvi;
	logic pin_low;
	logic internal_src;
	logic phase_done;
	logic nxt_drive;
	logic nxt_clocks_on;
	logic [7:0] rd_mux;

	// ------------------------------------------------------------
	// Fast clock divider
	// ------------------------------------------------------------
	// The fast clock is a half-rate phase; its fall is the counter step
	assign fast_fall = osc_enable && fast_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			fast_ff <= 1'b0;
		end else if (osc_enable) begin
			fast_ff <= !fast_ff;
		end
	end

	// Bus clock enable every fourth fast cycle, only when clocks are released
	always_ff @(posedge clk) begin
		if (rst) begin
			bus_div_ff <= 2'h0;
			bus_clk_en <= 1'b0;
		end else begin
			if (fast_fall) begin
				bus_div_ff <= bus_div_ff + 2'h1;
			end
			bus_clk_en <= fast_fall && (bus_div_ff == rsq_pkg::BUS_DIV_LAST) && nxt_clocks_on;
		end
	end

	// Oscillator is held off while power-on is asserted and during stop
	always_ff @(posedge clk) begin
		if (rst || power_on_reset_signal) begin
			osc_enable <= 1'b0;
		end else begin
			osc_enable <= (nxt_state != rsq_pkg::ST_STOP);
		end
	end

	// ------------------------------------------------------------
	// Stabilisation counter
	// ------------------------------------------------------------
	// Steps only on the fall of the fast clock phase
	rsq_stab_counter u_counter (
		.clk(clk),
		.rst(rst),
		.step_en(fast_fall),
		.clear(cnt_clear),
		.count(cnt),
		.wdog_tick(wdog_clk)
	);

	// Every entry into a timed phase restarts the count; a pin reset is no entry
	assign cnt_clear = power_on_reset_signal || src_lvi
		|| (state_ff == rsq_pkg::ST_STOP)
		|| ((nxt_state != state_ff) && (nxt_state != rsq_pkg::ST_RUN));

	// ------------------------------------------------------------
	// Reset source decode
	// ------------------------------------------------------------
	assign src_lvi = low_voltage_detector;
	assign src_illegal_opcode_flag = (state_ff == rsq_pkg::ST_RUN)
		&& (illegal_opcode_in
		|| (stop_exec && !cfg_ff[rsq_pkg::CFG_STOP_EN]));
	// A data fetch from a hole is harmless; only an opcode fetch resets
	assign src_illegal_address_flag = (state_ff == rsq_pkg::ST_RUN) && unmapped_access && opcode_fetch;
	assign internal_src = src_illegal_opcode_flag || src_illegal_address_flag || wdog_timeout;
	// Our own drive reads back low on the pin, so it is not an outside reset
	assign pin_low = !rst_pin_in && rst_pin_oe_n;

	// Length of the current timed phase
	always_comb begin
		unique case (state_ff)
			rsq_pkg::ST_LONG_WAIT: phase_done = (cnt >= LONG_FAST_CYC);
			rsq_pkg::ST_PIN_DRIVE: phase_done = (cnt >= rsq_pkg::PIN_DRIVE_LEN);
			rsq_pkg::ST_TAIL: phase_done = (cnt >= rsq_pkg::TAIL_LEN);
			rsq_pkg::ST_STOP_REC: phase_done = rec_short_ff ? (cnt >= rsq_pkg::SHORT_RECOVERY)
				: (cnt >= LONG_FAST_CYC);
			default: phase_done = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Sequencer state machine
	// ------------------------------------------------------------
	// Resets win over everything and never pass through arbitration
	always_comb begin
		nxt_state = state_ff;
		if (power_on_reset_signal) begin
			nxt_state = rsq_pkg::ST_LONG_WAIT;
		end else if (src_lvi) begin
			nxt_state = rsq_pkg::ST_LVI_HOLD;
		end else if (internal_src) begin
			nxt_state = rsq_pkg::ST_PIN_DRIVE;
		end else begin
			unique case (state_ff)
				rsq_pkg::ST_RUN: begin
					if (stop_exec && cfg_ff[rsq_pkg::CFG_STOP_EN]) begin
						nxt_state = rsq_pkg::ST_STOP;
					end
				end
				rsq_pkg::ST_LVI_HOLD: nxt_state = rsq_pkg::ST_LONG_WAIT;
				rsq_pkg::ST_LONG_WAIT: begin
					if (phase_done) begin
						nxt_state = rsq_pkg::ST_PIN_DRIVE;
					end
				end
				rsq_pkg::ST_PIN_DRIVE: begin
					if (phase_done) begin
						nxt_state = rsq_pkg::ST_TAIL;
					end
				end
				rsq_pkg::ST_TAIL, rsq_pkg::ST_STOP_REC: begin
					if (phase_done) begin
						nxt_state = rsq_pkg::ST_RUN;
					end
				end
				rsq_pkg::ST_STOP: begin
					if (irq_wake || break_req || pin_low) begin
						nxt_state = rsq_pkg::ST_STOP_REC;
					end
				end
				default: nxt_state = rsq_pkg::ST_LONG_WAIT;
			endcase
		end
	end

	// Design reset behaves as a power-on
	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= rsq_pkg::ST_LONG_WAIT;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Recovery length is sampled once, at the moment stop is left
	always_ff @(posedge clk) begin
		if (rst) begin
			rec_short_ff <= 1'b0;
		end else if (state_ff == rsq_pkg::ST_STOP && nxt_state == rsq_pkg::ST_STOP_REC) begin
			rec_short_ff <= cfg_ff[rsq_pkg::CFG_SHORT_REC];
		end
	end

	// ------------------------------------------------------------
	// Pin, core reset and mode outputs
	// ------------------------------------------------------------
	assign nxt_drive = (nxt_state == rsq_pkg::ST_LONG_WAIT) || (nxt_state == rsq_pkg::ST_LVI_HOLD)
		|| (nxt_state == rsq_pkg::ST_PIN_DRIVE);
	assign nxt_clocks_on = (nxt_state == rsq_pkg::ST_RUN) || (nxt_state == rsq_pkg::ST_PIN_DRIVE)
		|| (nxt_state == rsq_pkg::ST_TAIL);

	// Pin is open drain: the level is always low, only the enable moves
	always_ff @(posedge clk) begin
		if (rst) begin
			rst_pin_out <= 1'b0;
			rst_pin_oe_n <= 1'b0;
			core_reset <= 1'b1;
			stop_mode <= 1'b0;
		end else begin
			rst_pin_out <= 1'b0;
			rst_pin_oe_n <= !nxt_drive;
			core_reset <= nxt_drive || (nxt_state == rsq_pkg::ST_TAIL) || pin_low;
			stop_mode <= (nxt_state == rsq_pkg::ST_STOP);
		end
	end

	// ------------------------------------------------------------
	// Reset cause register
	// ------------------------------------------------------------
	// Read clears, but a cause arriving in the same cycle survives the clear
	always_ff @(posedge clk) begin
		if (rst || power_on_reset_signal) begin
			cause_ff <= rsq_pkg::CAUSE_RESET;
		end else begin
			cause_ff <= ((reg_rd && reg_addr == rsq_pkg::REG_CAUSE) ? 8'h00 : cause_ff)
				| (8'(src_illegal_opcode_flag) << rsq_pkg::CAUSE_ILLEGAL_OPCODE_FLAG)
				| (8'(src_illegal_address_flag) << rsq_pkg::CAUSE_ILLEGAL_ADDRESS_FLAG)
				| (8'(wdog_timeout) << rsq_pkg::CAUSE_COP)
				| (8'(pin_low) << rsq_pkg::CAUSE_PIN)
				| (8'(src_lvi) << rsq_pkg::CAUSE_LVI);
		end
	end

	// ------------------------------------------------------------
	// Register writes and reads
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_ff <= rsq_pkg::CFG_RESET;
			en_ff <= 19'h00000;
		end else if (reg_wr) begin
			unique case (reg_addr)
				rsq_pkg::REG_CONFIG_REG_ONE: cfg_ff <= reg_wdata[1:0];
				rsq_pkg::REG_EN0: en_ff[7:0] <= reg_wdata;
				rsq_pkg::REG_EN1: en_ff[15:8] <= reg_wdata;
				rsq_pkg::REG_EN2: en_ff[18:16] <= reg_wdata[2:0];
				default: ;
			endcase
		end
	end

	// Unmapped offsets read as zero
	always_comb begin
		unique case (reg_addr)
			rsq_pkg::REG_CAUSE: rd_mux = cause_ff;
			rsq_pkg::REG_CONFIG_REG_ONE: rd_mux = {6'h00, cfg_ff};
			rsq_pkg::REG_EN0: rd_mux = en_ff[7:0];
			rsq_pkg::REG_EN1: rd_mux = en_ff[15:8];
			rsq_pkg::REG_EN2: rd_mux = {5'h00, en_ff[18:16]};
			rsq_pkg::REG_PEND0: rd_mux = pend[7:0];
			rsq_pkg::REG_PEND1: rd_mux = pend[15:8];
			rsq_pkg::REG_PEND2: rd_mux = {5'h00, pend[18:16]};
			rsq_pkg::REG_SEQ: rd_mux = {4'h0, rec_short_ff, state_ff};
			default: rd_mux = 8'h00;
		endcase
	end

	// Data stands for the one cycle after the read strobe only
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Interrupt arbitration
	// ------------------------------------------------------------
	rsq_irq_arbiter u_irq (
		.clk(clk),
		.rst(rst),
		.src_req(src_req),
		.src_en(en_ff),
		.i_mask(cpu_i_mask),
		.insn_done(insn_done),
		.swi_exec(swi_exec),
		.int_ack(int_ack),
		.core_reset(core_reset),
		.pending(pend),
		.wake(irq_wake),
		.int_req(int_req),
		.int_vector(int_vector)
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst || power_on_reset_signal || src_lvi);

	sequence s_drive_begin;
		state_ff == rsq_pkg::ST_PIN_DRIVE && $past(state_ff) != rsq_pkg::ST_PIN_DRIVE;
	endsequence
	sequence s_tail_begin;
		state_ff == rsq_pkg::ST_TAIL && $past(state_ff) == rsq_pkg::ST_PIN_DRIVE;
	endsequence

	a_illegal_opcode_flag_flag_reset: assert property (src_illegal_opcode_flag |=> cause_ff[rsq_pkg::CAUSE_ILLEGAL_OPCODE_FLAG] && core_reset && state_ff == rsq_pkg::ST_PIN_DRIVE) else $error("illegal opcode not acted on");
	a_stop_disabled: assert property ((state_ff == rsq_pkg::ST_RUN) && stop_exec && !cfg_ff[rsq_pkg::CFG_STOP_EN] |=> cause_ff[rsq_pkg::CAUSE_ILLEGAL_OPCODE_FLAG] && !stop_mode) else $error("stop not trapped");
	a_pin_driven: assert property (s_drive_begin |-> !rst_pin_oe_n [*8]) else $error("pin not driven");
	a_data_fetch_safe: assert property (unmapped_access && !opcode_fetch && !internal_src |=> !$rose(cause_ff[rsq_pkg::CAUSE_ILLEGAL_ADDRESS_FLAG])) else $error("data fetch reset");
	a_long_pin_low: assert property (state_ff == rsq_pkg::ST_LONG_WAIT |-> !rst_pin_oe_n && core_reset && !bus_clk_en) else $error("long wait outputs");
	a_drive_length: assert property (s_drive_begin ##1 (!internal_src) [*8] |-> ##[55:58] state_ff == rsq_pkg::ST_TAIL) else $error("pin drive length");
	a_tail_release: assert property (s_tail_begin ##1 (!internal_src && !pin_low) [*8] |-> ##[55:58] !core_reset) else $error("release timing");
	a_falling_step: assert property (!$past(cnt_clear) && cnt != $past(cnt) |-> $past(fast_ff)) else $error("counter stepped off phase");
	a_stop_clears: assert property (state_ff == rsq_pkg::ST_STOP |=> cnt == 13'h0000) else $error("stop kept count");
	a_short_recovery: assert property ($rose(state_ff == rsq_pkg::ST_STOP_REC) && cfg_ff[rsq_pkg::CFG_SHORT_REC] ##1 (!internal_src) [*8] |-> ##[53:60] state_ff == rsq_pkg::ST_RUN) else $error("short recovery length");
	a_pin_keeps_count: assert property (state_ff == rsq_pkg::ST_RUN && pin_low && !internal_src && !stop_exec |=> !$past(cnt_clear)) else $error("pin reset cleared counter");
	a_recovery_gated: assert property (state_ff == rsq_pkg::ST_STOP_REC |-> !bus_clk_en) else $error("bus clock during recovery");

endmodule : rsq_system_sequencer

// ==== pkg/rsq_pkg.sv ====
// Shared constants and types for the reset and interrupt sequencer
package rsq_pkg;

	// ------------------------------------------------------------
	// Stabilisation counter
	// ------------------------------------------------------------
	localparam int CNT_W = 13;
	localparam logic [12:0] LONG_RECOVERY = 13'h1000; // 4096 fast-clock cycles
	localparam logic [12:0] SHORT_RECOVERY = 13'h0020; // 32 fast-clock cycles
	localparam logic [12:0] PIN_DRIVE_LEN = 13'h0020; // 32 fast-clock cycles
	localparam logic [12:0] TAIL_LEN = 13'h0020; // 32 further cycles
	localparam int STAGE13_BIT = 12;
	localparam logic [1:0] BUS_DIV_LAST = 2'h3; // Bus clock is fast clock / 4

	// ------------------------------------------------------------
	// Interrupt sources and vectors
	// ------------------------------------------------------------
	localparam int NUM_SRC = 19;
	localparam logic [15:0] VEC_RESET = 16'hfffe;
	localparam logic [15:0] VEC_SWI = 16'hfffc;
	localparam logic [15:0] VEC_FIRST = 16'hfffa; // First flag, step of two per flag

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CAUSE = 8'h00;
	localparam logic [7:0] REG_CONFIG_REG_ONE = 8'h01;
	localparam logic [7:0] REG_EN0 = 8'h02;
	localparam logic [7:0] REG_EN1 = 8'h03;
	localparam logic [7:0] REG_EN2 = 8'h04;
	localparam logic [7:0] REG_PEND0 = 8'h05;
	localparam logic [7:0] REG_PEND1 = 8'h06;
	localparam logic [7:0] REG_PEND2 = 8'h07;
	localparam logic [7:0] REG_SEQ = 8'h08;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int CAUSE_POR = 7;
	localparam int CAUSE_PIN = 6;
	localparam int CAUSE_COP = 5;
	localparam int CAUSE_ILLEGAL_OPCODE_FLAG = 4;
	localparam int CAUSE_ILLEGAL_ADDRESS_FLAG = 3;
	localparam int CAUSE_LVI = 1;
	localparam logic [7:0] CAUSE_RESET = 8'h80;
	localparam int CFG_SHORT_REC = 0;
	localparam int CFG_STOP_EN = 1;
	localparam logic [1:0] CFG_RESET = 2'h0;

	// ------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_RUN = 3'h0,
		ST_LONG_WAIT = 3'h1,
		ST_LVI_HOLD = 3'h2,
		ST_PIN_DRIVE = 3'h3,
		ST_TAIL = 3'h4,
		ST_STOP = 3'h5,
		ST_STOP_REC = 3'h6
	} rsq_state_e;

endpackage : rsq_pkg

// ==== rtl/rsq_stab_counter.sv ====
// Thirteen-stage stabilisation counter with watchdog prescale output
`timescale 1ns/100ps
module rsq_stab_counter (
	input wire logic clk,
	input wire logic rst,
	input wire logic step_en,
	input wire logic clear,
	output logic [12:0] count,
	output logic wdog_tick
);

	// ------------------------------------------------------------
	// Counter chain
	// ------------------------------------------------------------
	// Twelve counting stages; the 13th stage resets the chain on the next step
	always_ff @(posedge clk) begin
		if (rst || clear) begin
			count <= 13'h0000;
		end else if (step_en) begin
			if (count[rsq_pkg::STAGE13_BIT]) begin
				count <= 13'h0000;
			end else begin
				count <= count + 13'h0001;
			end
		end
	end

	// One pulse per 13th-stage wrap feeds the watchdog
	always_ff @(posedge clk) begin
		if (rst) begin
			wdog_tick <= 1'b0;
		end else begin
			wdog_tick <= step_en && !clear && count[rsq_pkg::STAGE13_BIT];
		end
	end

endmodule : rsq_stab_counter

// ==== rtl/rsq_irq_arbiter.sv ====
// Interrupt pending flags, latch and fixed-priority vector selection
`timescale 1ns/100ps
module rsq_irq_arbiter (
	input wire logic clk,
	input wire logic rst,
	input wire logic [18:0] src_req,
	input wire logic [18:0] src_en,
	input wire logic i_mask,
	input wire logic insn_done,
	input wire logic swi_exec,
	input wire logic int_ack,
	input wire logic core_reset,
	output logic [18:0] pending,
	output logic wake,
	output logic int_req,
	output logic [15:0] int_vector
);

	logic mask_q_ff;
	logic mask_fall;
	logic [4:0] win_idx;
	logic any_ready;

	// ------------------------------------------------------------
	// Pending flags, one per source
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < rsq_pkg::NUM_SRC; gi++) begin : g_pend
			always_ff @(posedge clk) begin
				if (rst) begin
					pending[gi] <= 1'b0;
				end else begin
					pending[gi] <= src_req[gi];
				end
			end
		end
	endgenerate

	// Lowest index wins; the scan runs downward so the last hit is the best
	always_comb begin
		win_idx = 5'h00;
		any_ready = 1'b0;
		for (int i = rsq_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (pending[i] && src_en[i]) begin
				win_idx = 5'(i);
				any_ready = 1'b1;
			end
		end
	end

	assign wake = any_ready;
	assign mask_fall = mask_q_ff && !i_mask;

	always_ff @(posedge clk) begin
		if (rst) begin
			mask_q_ff <= 1'b1;
		end else begin
			mask_q_ff <= i_mask;
		end
	end

	// ------------------------------------------------------------
	// Latch and vector
	// ------------------------------------------------------------
	// Only instruction boundaries look at requests, so nothing aborts mid-instruction
	always_ff @(posedge clk) begin
		if (rst || core_reset) begin
			int_req <= 1'b0;
			int_vector <= rsq_pkg::VEC_RESET;
		end else if (int_req) begin
			if (int_ack || mask_fall) begin
				int_req <= 1'b0;
			end
		end else if (insn_done) begin
			if (swi_exec) begin
				int_req <= 1'b1;
				int_vector <= rsq_pkg::VEC_SWI;
			end else if (!i_mask && any_ready) begin
				int_req <= 1'b1;
				int_vector <= rsq_pkg::VEC_FIRST - {10'h000, win_idx, 1'b0};
			end
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst || core_reset);

	a_latch_holds: assert property (int_req && !int_ack && !mask_fall |=> int_req && $stable(int_vector)) else $error("latched vector changed");
	a_mask_blocks: assert property (!int_req && insn_done && i_mask && !swi_exec |=> !int_req) else $error("masked request taken");
	a_swi_unmasked: assert property (!int_req && insn_done && swi_exec |=> int_req && int_vector == rsq_pkg::VEC_SWI) else $error("software interrupt lost");

endmodule : rsq_irq_arbiter

// ==== dv/rsq_cpu_model.sv ====
// Behavioural CPU core model driving instruction boundaries and interrupt acknowledge
`timescale 1ns/100ps
module rsq_cpu_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic int_req,
	input wire logic core_reset,
	input wire logic swi_cmd,
	input wire logic mask_cmd,
	output logic insn_done,
	output logic swi_exec,
	output logic int_ack,
	output logic cpu_i_mask
);
	logic [2:0] cyc_ff;
	logic bound;

	// Boundary every eight cycles, held off while an interrupt is being taken
	assign bound = !rst && !core_reset && !int_req && !int_ack && cyc_ff == 3'h6;

	// Ack one cycle after the latch shows, so the vector is seen for a cycle first
	always_ff @(posedge clk) begin
		cyc_ff <= (rst || core_reset || int_ack) ? 3'h0 : cyc_ff + 3'h1;
		insn_done <= bound;
		swi_exec <= bound && swi_cmd;
		// Stacking is abstract here: no high index push return address kept
		int_ack <= !rst && int_req && !int_ack;
		cpu_i_mask <= rst || mask_cmd;
	end
endmodule : rsq_cpu_model

// ==== dv/rsq_system_sequencer_tb_top.sv ====
// Self-checking testbench for the reset and interrupt sequencer
`timescale 1ns/100ps
module rsq_system_sequencer_tb_top;
	logic clk = 1'b0, rst = 1'b1, por = 1'b0, lvd = 1'b0, illegal_opcode_flag = 1'b0, stp = 1'b0;
	logic unm = 1'b0, ofet = 1'b0, wdt = 1'b0, brk = 1'b0, swi_cmd = 1'b0, mask_cmd = 1'b1;
	logic wr = 1'b0, rd = 1'b0, pin_out, oe_n, core_rst, bus_en, osc, stop_m, wclk;
	logic int_req, done, software_interrupt, ack, imask, pin_lvl;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic [18:0] src = 19'h0;
	logic [15:0] vec;
	logic ext_low = 1'b0;
	int n_fail = 0, total_checks = 0;

	// Pull-up on the reset pin when nobody drives it
	assign pin_lvl = (oe_n ? 1'b1 : pin_out) & !ext_low;
	always #10 clk = ~clk;

	rsq_system_sequencer #(.LONG_FAST_CYC(13'h0040)) dut (.clk(clk), .rst(rst),
		.power_on_reset_signal(por), .low_voltage_detector(lvd), .illegal_opcode_in(illegal_opcode_flag),
		.stop_exec(stp), .unmapped_access(unm), .opcode_fetch(ofet), .wdog_timeout(wdt),
		.break_req(brk), .rst_pin_in(pin_lvl), .cpu_i_mask(imask), .insn_done(done),
		.swi_exec(software_interrupt), .int_ack(ack), .src_req(src), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .rst_pin_out(pin_out),
		.rst_pin_oe_n(oe_n), .core_reset(core_rst), .bus_clk_en(bus_en), .osc_enable(osc),
		.stop_mode(stop_m), .wdog_clk(wclk), .int_req(int_req), .int_vector(vec));

	rsq_cpu_model cpu (.clk(clk), .rst(rst), .int_req(int_req), .core_reset(core_rst),
		.swi_cmd(swi_cmd), .mask_cmd(mask_cmd), .insn_done(done), .swi_exec(software_interrupt),
		.int_ack(ack), .cpu_i_mask(imask));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task chk(input string name, input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task stop_test;
		if (n_fail == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test

	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// Read data stand only in the cycle after the strobe
	task rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask : rd_reg

	// Counts pin-driven cycles until the core leaves reset; a hang ends the run
	task wait_run(output int nlo);
		nlo = 0;
		for (int i = 0; i < 600; i++) begin
			@(posedge clk);
			#1;
			if (core_rst === 1'b0) return;
			if (oe_n === 1'b0) nlo++;
		end
		n_fail++;
		stop_test;
	endtask : wait_run

	task int_rst(input logic [7:0] c);
		int nlo;
		logic [7:0] v;
		@(posedge clk);
		illegal_opcode_flag <= 1'b0;
		unm <= 1'b0;
		ofet <= 1'b0;
		stp <= 1'b0;
		#1;
		chk("pin drive", 16'(oe_n), 16'h0);
		chk("core reset", 16'(core_rst), 16'h1);
		wait_run(nlo);
		chk("pin cycles", 16'(nlo >= 62 && nlo <= 66), 16'h1);
		rd_reg(rsq_pkg::REG_CAUSE, v);
		chk("cause", 16'(v), 16'(c));
	endtask : int_rst

	task wait_irq(input logic [15:0] e);
		repeat (3) @(posedge clk);
		for (int i = 0; i < 200; i++) begin
			@(posedge clk);
			#1;
			if (int_req === 1'b1) begin
				chk("vector", vec, e);
				return;
			end
		end
		n_fail++;
		stop_test;
	endtask : wait_irq

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_por;
		int nlo;
		logic [7:0] v;
		wait_run(nlo);
		chk("osc", 16'(osc), 16'h1);
		rd_reg(rsq_pkg::REG_CAUSE, v);
		chk("por cause", 16'(v), 16'h80);
		rd_reg(rsq_pkg::REG_CAUSE, v);
		chk("cause cleared", 16'(v), 16'h0);
	endtask : t_por

	task t_illegal_address_flag;
		@(posedge clk);
		unm <= 1'b1;
		@(posedge clk);
		unm <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("data fetch", 16'(core_rst), 16'h0);
		@(posedge clk);
		unm <= 1'b1;
		ofet <= 1'b1;
		int_rst(8'h08);
	endtask : t_illegal_address_flag

	task t_irq;
		logic [7:0] v;
		wr_reg(rsq_pkg::REG_EN0, 8'h04);
		wr_reg(rsq_pkg::REG_EN2, 8'h04);
		@(posedge clk);
		src <= 19'h40004;
		repeat (20) @(posedge clk);
		#1;
		chk("masked", 16'(int_req), 16'h0);
		rd_reg(rsq_pkg::REG_PEND2, v);
		chk("pending", 16'(v), 16'h04);
		@(posedge clk);
		mask_cmd <= 1'b0;
		wait_irq(16'hfff6);
		@(posedge clk);
		src <= 19'h40000;
		wait_irq(16'hffd6);
		@(posedge clk);
		src <= 19'h0;
		mask_cmd <= 1'b1;
		swi_cmd <= 1'b1;
		wait_irq(16'hfffc);
		@(posedge clk);
		swi_cmd <= 1'b0;
	endtask : t_irq

	// Short stop recovery left by break, then an outside pin reset
	task t_stop_pin;
		logic [7:0] v;
		wr_reg(rsq_pkg::REG_CONFIG_REG_ONE, 8'h03);
		@(posedge clk);
		stp <= 1'b1;
		@(posedge clk);
		stp <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("stop mode", 16'(stop_m), 16'h1);
		chk("stop osc", 16'(osc), 16'h0);
		@(posedge clk);
		brk <= 1'b1;
		@(posedge clk);
		brk <= 1'b0;
		repeat (40) @(posedge clk);
		#1;
		chk("rec bus clk", 16'(bus_en), 16'h0);
		rd_reg(rsq_pkg::REG_SEQ, v);
		chk("in recovery", 16'(v), 16'h0e);
		repeat (40) @(posedge clk);
		rd_reg(rsq_pkg::REG_SEQ, v);
		chk("recovered", 16'(v), 16'h08);
		@(posedge clk);
		ext_low <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("pin core reset", 16'(core_rst), 16'h1);
		@(posedge clk);
		ext_low <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("pin release", 16'(core_rst), 16'h0);
		rd_reg(rsq_pkg::REG_CAUSE, v);
		chk("pin cause", 16'(v), 16'h40);
	endtask : t_stop_pin

	// Main sequence: stop is disabled out of reset, so it must act as illegal
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_por;
		@(posedge clk);
		illegal_opcode_flag <= 1'b1;
		int_rst(8'h10);
		t_illegal_address_flag;
		@(posedge clk);
		stp <= 1'b1;
		int_rst(8'h10);
		t_irq;
		t_stop_pin;
		stop_test;
	end
endmodule : rsq_system_sequencer_tb_top
